// File: hdl/pms_pkg.sv
// Package of constants and types for the power mode selector
//
// Contract
// - STOP with wait enable set enters wait mode, never a stop mode.
// - STOP with wait clear and halt enable set enters a stop mode.
// - Illegal STOP gives reset if illegal reset disable clear, else exception.
// - STOP may enter loose standby or partial power-down as programmed.
// - Regulation request bit puts regulator in standby without STOP.
// - Debug enable refuses standby and power-down; full regulation kept.
// - Partial power-down holds regulator standby and switches logic off.
// - No direct move from one low-power mode into another; the code moves low-power run into low-power wait or stop3 and back.
// - Regulation request clear, no STOP: clocks normal, power on.
// - Low-power run: low clock, bypassed external mode, loose regulator.
// - Wait: peripheral clocks on, processor clock off unless debug enabled.
// - Low-power wait: processor off, peripherals slow, loose regulator.
// - Debug clock may gate off, restored on background pin falling edge.
// - Debug enabled maps low-power run, wait, stop3, stop2 to full ones.
// - Stop2 exits only on reset or clock wakeup; others on interrupt.
// - Background pin fall in low-power run returns to run, clears status.
package pms_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] PMS_OFS_OPTION = 12'h000;
  localparam logic [11:0] PMS_OFS_CPUCTL = 12'h004;
  localparam logic [11:0] PMS_OFS_PWR1 = 12'h008;
  localparam logic [11:0] PMS_OFS_PWR2 = 12'h00c;
  localparam logic [11:0] PMS_OFS_DBGCFG = 12'h010;
  localparam logic [11:0] PMS_OFS_MODE = 12'h014;

  // Field positions
  localparam int PMS_B_WAIT_ON_HALT_ENABLE = 0;
  localparam int PMS_B_HALTE = 1;
  localparam int PMS_B_IRD = 0;
  localparam int PMS_B_LOW_VOLTAGE_DETECT_ENABLE = 0;
  localparam int PMS_B_LOW_VOLTAGE_DETECT_IN_HALT_ENABLE = 1;
  localparam int PMS_B_LPR = 0;
  localparam int PMS_B_PARTIAL_POWERDOWN_REQ = 1;
  localparam int PMS_B_REGULATOR_STANDBY_STATUS = 2;
  localparam int PMS_B_WAKE_TO_FULL_RUN_ON_IRQ = 3;
  localparam int PMS_B_ENDBG = 0;

  // Reset values
  localparam logic [31:0] PMS_RST_OPTION = 32'h0000_0002;
  localparam logic [31:0] PMS_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] PMS_RST_PWR1 = 32'h0000_0003;

  // Debug clock on-time after a pin fall, in cycles
  localparam int PMS_DBG_WAKE_CYC = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [6:0] {
    PMS_RUN    = 7'h01,
    PMS_LOW_POWER_RUN  = 7'h02,
    PMS_WAIT   = 7'h04,
    PMS_LOW_POWER_WAIT = 7'h08,
    PMS_STOP4  = 7'h10,
    PMS_STOP3  = 7'h20,
    PMS_STOP2  = 7'h40
  } pms_mode_e;

  // Control bits sampled when STOP completes
  typedef struct packed {
    logic wait_on_halt_enable;
    logic halte;
    logic illegal_reset_disable;
    logic endbg;
    logic lvd_on;
    logic low_power_regulation_req;
    logic partial_powerdown_req;
  } pms_ctl_s;

  // Gating outputs toward clocks and regulator
  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic per_clk_slow;
    logic mcg_bypassed_lowpower_external;
    logic reg_loose;
    logic sw_power_on;
  } pms_gate_s;

endpackage : pms_pkg

// File: hdl/pms_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pms_sync
  import pms_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  // First stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;

endmodule : pms_sync
`default_nettype wire

// File: hdl/pms_gate.sv
// Clock and regulator gating decode from current mode
`timescale 1ns/1ps
`default_nettype none
module pms_gate
  import pms_pkg::*;
(
  // Mode in
  input wire pms_mode_e mode,
  input wire logic endbg,
  // Gate out
  output pms_gate_s gate
);

  // Pure decode; registered in the top
  always_comb
  begin
    gate = '0;
    gate.sw_power_on = 1'b1;
    unique case (mode)
      PMS_RUN:
      begin
        gate.cpu_clk_en = 1'b1;
        gate.per_clk_en = 1'b1;
      end
      PMS_LOW_POWER_RUN:
      begin
        gate.cpu_clk_en = 1'b1;
        gate.per_clk_en = 1'b1;
        gate.per_clk_slow = 1'b1;
        gate.mcg_bypassed_lowpower_external = 1'b1;
        gate.reg_loose = 1'b1;
      end
      PMS_WAIT:
      begin
        gate.cpu_clk_en = endbg;
        gate.per_clk_en = 1'b1;
      end
      PMS_LOW_POWER_WAIT:
      begin
        gate.per_clk_en = 1'b1;
        gate.per_clk_slow = 1'b1;
        gate.mcg_bypassed_lowpower_external = 1'b1;
        gate.reg_loose = 1'b1;
      end
      PMS_STOP4:
        gate.cpu_clk_en = endbg;
      PMS_STOP3:
      begin
        gate.mcg_bypassed_lowpower_external = 1'b1;
        gate.reg_loose = 1'b1;
      end
      PMS_STOP2:
      begin
        gate.reg_loose = 1'b1;
        gate.sw_power_on = 1'b0;
      end
      default:
        gate = '0;
    endcase
  end

endmodule : pms_gate
`default_nettype wire

// File: hdl/pms_top.sv
// Power mode selector: STOP decode, regulator control, clock gating, APB
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pms_top
  import pms_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor events
  input wire logic STOP_DONE,
  input wire logic IRQ,
  // Wakeup sources
  input wire logic RTC_WAKE,
  input wire logic EXT_RESET_N,
  input wire logic BKGD_PIN,
  // Outcomes
  output logic ILLEGAL_RESET,
  output logic ILLEGAL_EXC,
  // Gating
  output logic CPU_CLK_EN,
  output logic PER_CLK_EN,
  output logic PER_CLK_SLOW,
  output logic MCG_BYPASSED_LOWPOWER_EXTERNAL,
  output logic REG_LOOSE,
  output logic SW_POWER_ON,
  output logic DBG_CLK_EN
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s;
  pms_sync #(.W(3)) u_sync (
    .clk(MCLK),
    .rst(SYS_RST),
    .d({RTC_WAKE, EXT_RESET_N, BKGD_PIN}),
    .q(pin_s)
  );
  logic rtc_s;
  logic extrst_n_s;
  logic bkgd_s;
  assign rtc_s = pin_s[2];
  assign extrst_n_s = pin_s[1];
  assign bkgd_s = pin_s[0];

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0] option_reg, option_next;
  logic ird_reg, ird_next;
  logic [1:0] lvd_reg, lvd_next;
  logic lpr_reg, lpr_next;
  logic partial_powerdown_req_reg, partial_powerdown_req_next;
  logic regulator_standby_status_reg, regulator_standby_status_next;
  logic wake_to_full_run_on_irq_reg, wake_to_full_run_on_irq_next;
  logic endbg_reg, endbg_next;
  pms_mode_e mode_reg, mode_next;
  logic bkgd_d_reg;
  logic ill_rst_reg, ill_rst_next;
  logic ill_exc_reg, ill_exc_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic [2:0] dbg_cnt_reg, dbg_cnt_next;
  pms_gate_s gate_reg;
  pms_gate_s gate_c;
  pms_ctl_s smp;

  logic wr;
  logic rd;
  logic bkgd_fall;
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE; // Setup cycle, so data stands in access
  assign bkgd_fall = bkgd_d_reg && !bkgd_s;

  // Address decode, used by read and write
  function automatic logic hit(input logic [11:0] a);
    hit = (a == PMS_OFS_OPTION) || (a == PMS_OFS_CPUCTL) || (a == PMS_OFS_PWR1) ||
          (a == PMS_OFS_PWR2) || (a == PMS_OFS_DBGCFG) || (a == PMS_OFS_MODE);
  endfunction : hit

  function automatic logic is_lp(input pms_mode_e m);
    is_lp = (m != PMS_RUN);
  endfunction : is_lp

  // Snapshot of control bits at STOP completion
  always_comb
  begin
    smp.wait_on_halt_enable = option_reg[PMS_B_WAIT_ON_HALT_ENABLE];
    smp.halte = option_reg[PMS_B_HALTE];
    smp.illegal_reset_disable = ird_reg;
    smp.endbg = endbg_reg;
    smp.lvd_on = lvd_reg[PMS_B_LOW_VOLTAGE_DETECT_ENABLE] && lvd_reg[PMS_B_LOW_VOLTAGE_DETECT_IN_HALT_ENABLE];
    smp.low_power_regulation_req = lpr_reg;
    smp.partial_powerdown_req = partial_powerdown_req_reg;
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    ill_rst_next = 1'b0;
    ill_exc_next = 1'b0;
    unique case (mode_reg)
      PMS_RUN, PMS_LOW_POWER_RUN:
      begin
        if (STOP_DONE)
        begin
          if (smp.wait_on_halt_enable)
            mode_next = (mode_reg == PMS_LOW_POWER_RUN && !smp.endbg) ? PMS_LOW_POWER_WAIT : PMS_WAIT;
          else if (smp.halte)
          begin
            if (smp.endbg || smp.lvd_on || (!smp.low_power_regulation_req && !smp.partial_powerdown_req))
              mode_next = PMS_STOP4;
            else if (smp.partial_powerdown_req && mode_reg == PMS_RUN)
              mode_next = PMS_STOP2;
            else if (mode_reg == PMS_LOW_POWER_RUN)
              mode_next = PMS_STOP3;
            else
              mode_next = PMS_STOP4;
          end
          else
          begin
            ill_rst_next = !smp.illegal_reset_disable;
            ill_exc_next = smp.illegal_reset_disable;
          end
        end
        else if (mode_reg == PMS_RUN && lpr_reg && !partial_powerdown_req_reg && !endbg_reg &&
                 !(lvd_reg[PMS_B_LOW_VOLTAGE_DETECT_ENABLE] && lvd_reg[PMS_B_LOW_VOLTAGE_DETECT_IN_HALT_ENABLE]))
          mode_next = PMS_LOW_POWER_RUN;
        else if (mode_reg == PMS_LOW_POWER_RUN && (!lpr_reg || endbg_reg || bkgd_fall ||
                 (IRQ && wake_to_full_run_on_irq_reg)))
          mode_next = PMS_RUN;
      end
      PMS_WAIT, PMS_STOP4:
        if (IRQ)
          mode_next = PMS_RUN;
      PMS_LOW_POWER_WAIT, PMS_STOP3:
        if (IRQ)
          mode_next = wake_to_full_run_on_irq_reg ? PMS_RUN : PMS_LOW_POWER_RUN;
      PMS_STOP2:
        if (rtc_s || !extrst_n_s)
          mode_next = PMS_RUN;
      default:
        mode_next = PMS_RUN;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      mode_reg <= PMS_RUN;
      ill_rst_reg <= 1'b0;
      ill_exc_reg <= 1'b0;
      bkgd_d_reg <= 1'b0; // Matches the synchroniser's reset, so no false fall
    end
    else
    begin
      mode_reg <= mode_next;
      ill_rst_reg <= ill_rst_next;
      ill_exc_reg <= ill_exc_next;
      bkgd_d_reg <= bkgd_s;
    end
  end

  // ----------------------------------------
  // Registers and APB
  // ----------------------------------------
  always_comb
  begin
    option_next = option_reg;
    ird_next = ird_reg;
    lvd_next = lvd_reg;
    lpr_next = lpr_reg;
    partial_powerdown_req_next = partial_powerdown_req_reg;
    wake_to_full_run_on_irq_next = wake_to_full_run_on_irq_reg;
    endbg_next = endbg_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    // Decode in the setup cycle so error and read data stand with PREADY
    if (PSEL && !PENABLE)
      pslverr_next = !hit(PADDR);
    if (wr)
    begin
      unique case (PADDR)
        PMS_OFS_OPTION: option_next = PWDATA[1:0];
        PMS_OFS_CPUCTL: ird_next = PWDATA[PMS_B_IRD];
        PMS_OFS_PWR1: lvd_next = PWDATA[1:0];
        PMS_OFS_PWR2:
        begin
          lpr_next = PWDATA[PMS_B_LPR];
          partial_powerdown_req_next = PWDATA[PMS_B_PARTIAL_POWERDOWN_REQ];
          wake_to_full_run_on_irq_next = PWDATA[PMS_B_WAKE_TO_FULL_RUN_ON_IRQ];
        end
        PMS_OFS_DBGCFG: endbg_next = PWDATA[PMS_B_ENDBG];
        default: pslverr_next = 1'b0; // Read-only and unmapped writes dropped
      endcase
    end
    // Leaving low-power run by pin or interrupt drops the request; a request write wins
    if (mode_reg == PMS_LOW_POWER_RUN && mode_next == PMS_RUN && !(wr && PADDR == PMS_OFS_PWR2))
      lpr_next = 1'b0;
    if (rd)
    begin
      unique case (PADDR)
        PMS_OFS_OPTION: prdata_next = {30'h0, option_reg};
        PMS_OFS_CPUCTL: prdata_next = {31'h0, ird_reg};
        PMS_OFS_PWR1: prdata_next = {30'h0, lvd_reg};
        PMS_OFS_PWR2: prdata_next = {28'h0, wake_to_full_run_on_irq_reg, regulator_standby_status_reg, partial_powerdown_req_reg, lpr_reg};
        PMS_OFS_DBGCFG: prdata_next = {31'h0, endbg_reg};
        PMS_OFS_MODE: prdata_next = {25'h0, mode_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  // Standby status: refused while debug holds full regulation
  always_comb
  begin
    regulator_standby_status_next = gate_c.reg_loose && !endbg_reg;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      option_reg <= PMS_RST_OPTION[1:0];
      ird_reg <= PMS_RST_ZERO[0];
      lvd_reg <= PMS_RST_PWR1[1:0];
      lpr_reg <= PMS_RST_ZERO[0];
      partial_powerdown_req_reg <= PMS_RST_ZERO[0];
      regulator_standby_status_reg <= PMS_RST_ZERO[0];
      wake_to_full_run_on_irq_reg <= PMS_RST_ZERO[0];
      endbg_reg <= PMS_RST_ZERO[0];
      prdata_reg <= PMS_RST_ZERO;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      option_reg <= option_next;
      ird_reg <= ird_next;
      lvd_reg <= lvd_next;
      lpr_reg <= lpr_next;
      partial_powerdown_req_reg <= partial_powerdown_req_next;
      regulator_standby_status_reg <= regulator_standby_status_next;
      wake_to_full_run_on_irq_reg <= wake_to_full_run_on_irq_next;
      endbg_reg <= endbg_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ----------------------------------------
  // Gating and debug clock
  // ----------------------------------------
  pms_gate u_gate (
    .mode(mode_next),
    .endbg(endbg_reg),
    .gate(gate_c)
  );

  // Debug clock idles off, wakes for a few cycles on a pin fall
  always_comb
  begin
    dbg_cnt_next = dbg_cnt_reg;
    if (bkgd_fall)
      dbg_cnt_next = 3'(PMS_DBG_WAKE_CYC);
    else if (dbg_cnt_reg != 3'h0)
      dbg_cnt_next = dbg_cnt_reg - 3'h1;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      gate_reg <= '0;
      dbg_cnt_reg <= 3'h0;
    end
    else
    begin
      gate_reg <= gate_c;
      gate_reg.reg_loose <= gate_c.reg_loose && !endbg_reg;
      dbg_cnt_reg <= dbg_cnt_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = pslverr_reg && PSEL && PENABLE;
  assign ILLEGAL_RESET = ill_rst_reg;
  assign ILLEGAL_EXC = ill_exc_reg;
  assign CPU_CLK_EN = gate_reg.cpu_clk_en;
  assign PER_CLK_EN = gate_reg.per_clk_en;
  assign PER_CLK_SLOW = gate_reg.per_clk_slow;
  assign MCG_BYPASSED_LOWPOWER_EXTERNAL = gate_reg.mcg_bypassed_lowpower_external;
  assign REG_LOOSE = gate_reg.reg_loose;
  assign SW_POWER_ON = gate_reg.sw_power_on;
  assign DBG_CLK_EN = endbg_reg || (dbg_cnt_reg != 3'h0);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_wait_entry;
    @(posedge MCLK) disable iff (SYS_RST)
    (STOP_DONE && mode_reg == PMS_RUN && option_reg[PMS_B_WAIT_ON_HALT_ENABLE]) |=> mode_reg == PMS_WAIT;
  endproperty
  a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");

  property p_stop_entry;
    @(posedge MCLK) disable iff (SYS_RST)
    (STOP_DONE && !is_lp(mode_reg) && option_reg == 2'b10) |=>
      (mode_reg == PMS_STOP4 || mode_reg == PMS_STOP2);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");

  property p_illegal;
    @(posedge MCLK) disable iff (SYS_RST)
    (STOP_DONE && mode_reg == PMS_RUN && option_reg == 2'b00) |=>
      (ILLEGAL_RESET == !$past(ird_reg) && ILLEGAL_EXC == $past(ird_reg));
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal stop outcome wrong");

  property p_dbg_full;
    @(posedge MCLK) disable iff (SYS_RST)
    endbg_reg [*2] |-> !REG_LOOSE && mode_reg != PMS_STOP2;
  endproperty
  a_dbg_full: assert property (p_dbg_full) else $error("loose regulation under debug");

  property p_pd_off;
    @(posedge MCLK) disable iff (SYS_RST)
    (mode_reg == PMS_STOP2) |=> (!SW_POWER_ON && REG_LOOSE) || mode_reg != PMS_STOP2;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("power-down gating wrong");

  property p_wait_cpu;
    @(posedge MCLK) disable iff (SYS_RST)
    (mode_reg == PMS_WAIT && $stable(mode_reg)) |->
      PER_CLK_EN && CPU_CLK_EN == $past(endbg_reg);
  endproperty
  a_wait_cpu: assert property (p_wait_cpu) else $error("wait clocks wrong");

  property p_stop2_exit;
    @(posedge MCLK) disable iff (SYS_RST)
    (mode_reg == PMS_STOP2 && rtc_s == 1'b0 && extrst_n_s) |=> mode_reg == PMS_STOP2;
  endproperty
  a_stop2_exit: assert property (p_stop2_exit) else $error("stop2 left early");

  property p_bkgd_exit;
    @(posedge MCLK) disable iff (SYS_RST)
    (mode_reg == PMS_LOW_POWER_RUN && bkgd_fall && !STOP_DONE) |=> mode_reg == PMS_RUN ##1 !regulator_standby_status_reg;
  endproperty
  a_bkgd_exit: assert property (p_bkgd_exit) else $error("pin fall did not exit");

  property p_no_lp_hop;
    @(posedge MCLK) disable iff (SYS_RST)
    (mode_reg == PMS_STOP3) |=> mode_reg inside {PMS_STOP3, PMS_RUN, PMS_LOW_POWER_RUN};
  endproperty
  a_no_lp_hop: assert property (p_no_lp_hop) else $error("low-power hop");

  c_wait: cover property (@(posedge MCLK) mode_reg == PMS_WAIT);
  c_stop2: cover property (@(posedge MCLK) mode_reg == PMS_STOP2);
  c_low_power_wait: cover property (@(posedge MCLK) mode_reg == PMS_LOW_POWER_WAIT);
  c_illegal: cover property (@(posedge MCLK) ILLEGAL_RESET || ILLEGAL_EXC);

endmodule : pms_top
`default_nettype wire

// File: verif/pms_cpu_model.sv
// Model of the processor core and debug pin facing the power mode selector
`timescale 1ns/1ps
`default_nettype none
module pms_cpu_model
(
  // Clock
  input wire logic clk,
  // Processor events
  output logic stop_done,
  output logic irq,
  // Wakeup pins
  output logic rtc_wake,
  output logic ext_reset_n,
  output logic bkgd_pin
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  // Pins idle at their inactive levels as on the board
  initial
  begin
    stop_done = 1'b0;
    irq = 1'b0;
    rtc_wake = 1'b0;
    ext_reset_n = 1'b1;
    bkgd_pin = 1'b1;
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  // One-cycle completion of a STOP instruction
  task automatic fire_stop();
    @(posedge clk);
    stop_done <= 1'b1;
    @(posedge clk);
    stop_done <= 1'b0;
  endtask : fire_stop

  // Pin activity: 0 interrupt, 1 clock wakeup, 2 debug pin fall, 3 reset pin
  task automatic pulse_pin(input int sel);
    @(posedge clk);
    if (sel == 0) irq <= 1'b1;
    else if (sel == 1) rtc_wake <= 1'b1;
    else if (sel == 2) bkgd_pin <= 1'b0;
    else ext_reset_n <= 1'b0;
    // Held long enough to pass the two-flop synchronisers
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    rtc_wake <= 1'b0;
    bkgd_pin <= 1'b1;
    ext_reset_n <= 1'b1;
  endtask : pulse_pin
endmodule : pms_cpu_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the power mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pms_pkg::*;
;
  logic MCLK;
  logic SYS_RST;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr, stop_done, irq, rtc_wake, ext_reset_n, bkgd_pin;
  logic ill_rst, ill_exc, cpu_en, per_en, per_slow, bypassed_lowpower_external, loose, sw_on, dbg_en;
  logic [31:0] q;
  logic err;
  int fail_count = 0;
  int total_checks = 0;
  int n_rst = 0;
  int n_exc = 0;
  int i;

  // Clock at 100 MHz
  always #5 MCLK = ~MCLK;

  pms_cpu_model cpu (.clk(MCLK), .stop_done(stop_done), .irq(irq), .rtc_wake(rtc_wake),
    .ext_reset_n(ext_reset_n), .bkgd_pin(bkgd_pin));

  pms_top dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STOP_DONE(stop_done), .IRQ(irq), .RTC_WAKE(rtc_wake),
    .EXT_RESET_N(ext_reset_n), .BKGD_PIN(bkgd_pin), .ILLEGAL_RESET(ill_rst),
    .ILLEGAL_EXC(ill_exc), .CPU_CLK_EN(cpu_en), .PER_CLK_EN(per_en),
    .PER_CLK_SLOW(per_slow), .MCG_BYPASSED_LOWPOWER_EXTERNAL(bypassed_lowpower_external), .REG_LOOSE(loose), .SW_POWER_ON(sw_on),
    .DBG_CLK_EN(dbg_en));

  // Pulse counters, so a one-cycle outcome cannot be missed between polls
  always @(posedge MCLK)
  begin
    if (ill_rst === 1'b1) n_rst++;
    if (ill_exc === 1'b1) n_exc++;
  end

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // ----------------------------------------
  // APB master
  // ----------------------------------------
  // Read data and error stand in the access cycle and are taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge MCLK);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge MCLK);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk(32'h1, 32'h0);
      final_report();
    end
    err = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge MCLK);
  endtask : apb

  // Poll the mode register until it shows the expected one-hot value
  task automatic expect_mode(input logic [31:0] exp);
    int n;
    n = 0;
    q = 32'h0;
    while (n < 12 && q !== exp)
    begin
      apb(1'b0, PMS_OFS_MODE, 32'h0);
      n++;
    end
    chk(q, exp);
  endtask : expect_mode

  // Order: cpu, per, slow, bypassed_lowpower_external, loose, switched power
  task automatic gate(input logic [5:0] exp);
    #1;
    chk({26'h0, cpu_en, per_en, per_slow, bypassed_lowpower_external, loose, sw_on}, {26'h0, exp});
  endtask : gate

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    MCLK = 1'b0;
    SYS_RST = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    apb(1'b0, PMS_OFS_OPTION, 32'h0);
    chk(q, PMS_RST_OPTION);
    apb(1'b0, PMS_OFS_PWR1, 32'h0);
    chk(q, PMS_RST_PWR1);
    expect_mode(32'h01);
    gate(6'b110001);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Wait mode; option change after STOP must not alter the outcome
    apb(1'b1, PMS_OFS_OPTION, 32'h3);
    cpu.fire_stop();
    apb(1'b1, PMS_OFS_OPTION, 32'h2);
    expect_mode(32'h04);
    gate(6'b010001);
    cpu.pulse_pin(0);
    expect_mode(32'h01);
    cpu.fire_stop();
    expect_mode(32'h10);
    gate(6'b000001);
    cpu.pulse_pin(0);
    expect_mode(32'h01);
    // Illegal STOP is issued here on purpose, both enables clear
    apb(1'b1, PMS_OFS_OPTION, 32'h0);
    cpu.fire_stop();
    repeat (3) @(posedge MCLK);
    chk(n_rst, 1);
    chk(n_exc, 0);
    apb(1'b1, PMS_OFS_CPUCTL, 32'h1);
    cpu.fire_stop();
    repeat (3) @(posedge MCLK);
    chk(n_rst, 1);
    chk(n_exc, 1);
    expect_mode(32'h01);
    // Low-power run, then wait and stop3 from it; never both requests set
    // Bench clock stands in for a bus clock below the standby limit
    apb(1'b1, PMS_OFS_PWR1, 32'h0);
    apb(1'b1, PMS_OFS_PWR2, 32'h1);
    expect_mode(32'h02);
    gate(6'b111111);
    apb(1'b1, PMS_OFS_OPTION, 32'h3);
    cpu.fire_stop();
    expect_mode(32'h08);
    gate(6'b011111);
    cpu.fire_stop();
    expect_mode(32'h08);
    cpu.pulse_pin(0);
    expect_mode(32'h02);
    apb(1'b1, PMS_OFS_OPTION, 32'h2);
    cpu.fire_stop();
    expect_mode(32'h20);
    cpu.pulse_pin(0);
    expect_mode(32'h02);
    // Interrupt with wake-to-run set leaves low-power run
    apb(1'b1, PMS_OFS_PWR2, 32'h9);
    cpu.pulse_pin(0);
    expect_mode(32'h01);
    apb(1'b1, PMS_OFS_PWR2, 32'h1);
    expect_mode(32'h02);
    cpu.pulse_pin(2);
    expect_mode(32'h01);
    apb(1'b0, PMS_OFS_PWR2, 32'h0);
    chk(q & 32'h5, 32'h0);
    // Debug clock is restored after a pin fall within a few cycles
    chk({31'h0, dbg_en}, 32'h0);
    cpu.pulse_pin(2);
    for (i = 0; i < 12 && dbg_en !== 1'b1; i++) @(posedge MCLK);
    chk({31'h0, dbg_en}, 32'h1);
    // Debug enable forces full regulation and maps low-power modes
    apb(1'b1, PMS_OFS_DBGCFG, 32'h1);
    apb(1'b1, PMS_OFS_PWR2, 32'h1);
    expect_mode(32'h01);
    gate(6'b110001);
    chk({31'h0, dbg_en}, 32'h1);
    apb(1'b1, PMS_OFS_OPTION, 32'h3);
    cpu.fire_stop();
    expect_mode(32'h04);
    gate(6'b110001);
    cpu.pulse_pin(0);
    expect_mode(32'h01);
    apb(1'b1, PMS_OFS_OPTION, 32'h2);
    apb(1'b1, PMS_OFS_PWR2, 32'h2);
    cpu.fire_stop();
    expect_mode(32'h10);
    cpu.pulse_pin(0);
    expect_mode(32'h01);
    // Partial power-down: an interrupt does not leave it, the clock wakeup does
    apb(1'b1, PMS_OFS_DBGCFG, 32'h0);
    cpu.fire_stop();
    expect_mode(32'h40);
    gate(6'b000010);
    cpu.pulse_pin(0);
    repeat (4) @(posedge MCLK);
    expect_mode(32'h40);
    cpu.pulse_pin(1);
    expect_mode(32'h01);
    // The reset pin leaves partial power-down as well
    cpu.fire_stop();
    expect_mode(32'h40);
    cpu.pulse_pin(3);
    expect_mode(32'h01);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
